// >>> shared/bpsr_map.svh
// Purpose: Register offsets, field positions, reset values and counts.
// Assumes: Included by its bare name wherever the constants are needed.
// Notes:   Definitions only; no logic lives here.
`ifndef BPSR_MAP_SVH
`define BPSR_MAP_SVH

// Register bus address width and register offsets.
`define BPSR_AW             14
`define BPSR_OFS_CTRL       14'h0000
`define BPSR_OFS_MODE       14'h0001
`define BPSR_OFS_SWRST      14'h0002

// Field positions in the control register.
`define BPSR_CTRL_FILL_EN   0

// Field positions in the mode select register.
`define BPSR_MODE_START     0
`define BPSR_MODE_PAT_LO    1
`define BPSR_MODE_PAT_HI    3
`define BPSR_MODE_RW_HI     8

// Field position in the software reset register.
`define BPSR_SWRST_BIT      1

// Reset values.
`define BPSR_RST_WORD       16'h0000
`define BPSR_RST_MODE_HI    5'h00
`define BPSR_RST_PAT        3'h0

// Frames that one block fill takes.
`define BPSR_FILL_FRAMES    2'h2
`define BPSR_FRAME_ZERO     2'h0
`define BPSR_FRAME_ONE      2'h1

`endif

// >>> shared/bpsr_pkg.sv
// Purpose: Types shared by the block fill control and its engine.
// Assumes: Nothing is imported; users write bpsr_pkg::name.
// Notes:   One-hot state codes are written out.
package bpsr_pkg;

	// Fill engine states, one-hot.
	typedef enum logic [2:0] {
		BPSR_IDLE = 3'b001,
		BPSR_ARM  = 3'b010,
		BPSR_FILL = 3'b100
	} bpsr_state_t;

endpackage

// >>> shared/bpsr_fill_if.sv
// Purpose: Carrier between the register bank and the block fill engine.
// Assumes: Both ends sit on the same clock.
// Notes:   launch, cancel and done are one-cycle pulses.
`timescale 1ns/1ps
interface bpsr_fill_if #(
	parameter int CM_AW = 11,
	parameter int CM_DW = 16
);
	logic             launch;
	logic             cancel;
	logic             enable;
	logic [2:0]       pattern;
	logic             done;
	logic             busy;
	logic             cm_wr_en;
	logic [CM_AW-1:0] cm_addr;
	logic [CM_DW-1:0] cm_wdata;

	modport ctl (
		output launch,
		output cancel,
		output enable,
		output pattern,
		input  done,
		input  busy,
		input  cm_wr_en,
		input  cm_addr,
		input  cm_wdata
	);

	modport eng (
		input  launch,
		input  cancel,
		input  enable,
		input  pattern,
		output done,
		output busy,
		output cm_wr_en,
		output cm_addr,
		output cm_wdata
	);
endinterface

// >>> design/bpsr_fill_engine.sv
// Purpose: Sequencer that fills every low connection memory word.
// Assumes: frame_pulse is a one-cycle strobe at each frame boundary.
// Notes:   The word count must fit inside two frames of clock cycles.
`timescale 1ns/1ps
`include "bpsr_map.svh"
module bpsr_fill_engine #(
	parameter int CM_AW = 11,
	parameter int CM_DW = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic frame_pulse,
	bpsr_fill_if.eng  fi
);
	bpsr_pkg::bpsr_state_t state_reg;
	bpsr_pkg::bpsr_state_t state_next;
	logic [CM_AW:0]        cnt_reg;
	logic [1:0]            frames_reg;
	logic [2:0]            pat_reg;
	logic                  done_reg;
	logic                  wr_reg;
	logic [CM_AW-1:0]      addr_reg;

	// Words remain while the counter has not wrapped into its top bit.
	wire words_left = ~cnt_reg[CM_AW];
	wire last_frame = frame_pulse & (frames_reg == `BPSR_FRAME_ONE);
	wire fill_end   = (state_reg == bpsr_pkg::BPSR_FILL) & last_frame;
	wire do_write   = (state_reg == bpsr_pkg::BPSR_FILL) & words_left
	                  & ~fi.cancel;

	// Next state; a cancel from any state drops back to idle at once.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bpsr_pkg::BPSR_IDLE: begin
				if (fi.launch) begin
					state_next = bpsr_pkg::BPSR_ARM;
				end
			end
			bpsr_pkg::BPSR_ARM: begin
				if (fi.cancel) begin
					state_next = bpsr_pkg::BPSR_IDLE;
				end else if (fi.enable & frame_pulse) begin
					state_next = bpsr_pkg::BPSR_FILL;
				end
			end
			bpsr_pkg::BPSR_FILL: begin
				if (fi.cancel | fill_end) begin
					state_next = bpsr_pkg::BPSR_IDLE;
				end
			end
			default: begin
				state_next = bpsr_pkg::BPSR_IDLE;
			end
		endcase
	end

	// Sequencer registers; the fill starts on a frame boundary so that it
	// spans exactly two whole frames.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg  <= bpsr_pkg::BPSR_IDLE;
			cnt_reg    <= '0;
			frames_reg <= `BPSR_FRAME_ZERO;
			pat_reg    <= `BPSR_RST_PAT;
			done_reg   <= 1'b0;
			wr_reg     <= 1'b0;
			addr_reg   <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			done_reg  <= fill_end & ~fi.cancel;
			wr_reg    <= do_write;
			addr_reg  <= cnt_reg[CM_AW-1:0];
			if (fi.launch) begin
				pat_reg <= fi.pattern;
			end
			if (state_reg != bpsr_pkg::BPSR_FILL) begin
				cnt_reg    <= '0;
				frames_reg <= `BPSR_FRAME_ZERO;
			end else begin
				if (do_write) begin
					cnt_reg <= cnt_reg + 1'b1;
				end
				if (frame_pulse) begin
					frames_reg <= frames_reg + 1'b1;
				end
			end
		end
	end

	// Pattern goes to the low bits; upper bits of each word are cleared.
	assign fi.cm_wdata = {{(CM_DW-3){1'b0}}, pat_reg};
	assign fi.cm_wr_en = wr_reg;
	assign fi.cm_addr  = addr_reg;
	assign fi.done     = done_reg;
	assign fi.busy     = (state_reg != bpsr_pkg::BPSR_IDLE);
endmodule

// >>> design/bpsr_top.sv
// Purpose: Register bank for connection memory block fill and switch
//          software reset.
// Assumes: One clock; all inputs synchronous to it; frame_pulse marks
//          frame boundaries.
//          Reset acts at any clock edge, even with the clock enable low.
// Notes:   Read data appear the cycle after the read strobe, only there.
//          The clock enable freezes every flop, the engine's included.
//          Unmapped addresses ignore writes and read as zero.
//          The switch reset bit does not reset this bank itself.
`timescale 1ns/1ps
`include "bpsr_map.svh"
module bpsr_top #(
	parameter int CM_AW = 11,
	parameter int CM_DW = 16
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic [`BPSR_AW-1:0] reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	input  wire logic              frame_pulse,
	output logic                   block_fill_enable,
	output logic [2:0]             block_fill_pattern,
	output logic [4:0]             mode_bits,
	output logic                   fill_busy,
	output logic                   switch_reset,
	output logic                   cm_wr_en,
	output logic [CM_AW-1:0]       cm_addr,
	output logic [CM_DW-1:0]       cm_wdata
);
	logic        en_reg;
	logic        start_reg;
	logic [2:0]  pat_reg;
	logic [4:0]  mode_hi_reg;
	logic        srst_reg;
	logic [15:0] rdata_reg;
	logic        busy_reg;
	logic        start_next;
	logic [15:0] rd_word;

	// Carrier to the fill engine; both ends share this clock.
	bpsr_fill_if #(
		.CM_AW (CM_AW),
		.CM_DW (CM_DW)
	) fill_bus ();

	// The engine sequences the words; this bank only decides when.
	bpsr_fill_engine #(
		.CM_AW (CM_AW),
		.CM_DW (CM_DW)
	) bpsr_fill_engine_i (
		.clk         (clk),
		.rst_n       (rst_n),
		.ce          (ce),
		.frame_pulse (frame_pulse),
		.fi          (fill_bus)
	);

	// Address decode for the three registers. Full-width compares keep
	// aliases out, so an unmapped address never reaches a register.
	wire sel_ctrl  = (reg_addr == `BPSR_OFS_CTRL);
	wire sel_mode  = (reg_addr == `BPSR_OFS_MODE);
	wire sel_swrst = (reg_addr == `BPSR_OFS_SWRST);
	wire wr_ctrl   = reg_wr & sel_ctrl;
	wire wr_mode   = reg_wr & sel_mode;
	wire wr_swrst  = reg_wr & sel_swrst;

	// Fields of the incoming write word. Every register takes its bits
	// from the positions it reads back at, on the one write data bus.
	wire       w_start = reg_wdata[`BPSR_MODE_START];
	wire [2:0] w_pat   = reg_wdata[`BPSR_MODE_PAT_HI:`BPSR_MODE_PAT_LO];
	wire [4:0] w_hi    = reg_wdata[`BPSR_MODE_RW_HI:`BPSR_MODE_PAT_HI+1];
	wire       w_en    = reg_wdata[`BPSR_CTRL_FILL_EN];
	wire       w_srst  = reg_wdata[`BPSR_SWRST_BIT];

	// Start and pattern travel in the same write, so the pattern latched
	// at launch is the one written with the start edge. A start bit that
	// is already high is not launched again, which makes the rewrite of
	// an unchanged mode word harmless during a fill.
	wire launch = wr_mode & w_start & ~start_reg;

	// Abort on a written zero to start, or on the enable falling while
	// start is high; a rewrite of the enable as one is no abort. An
	// enable that was already low is no abort either: the armed fill
	// simply waits for the enable and a frame boundary.
	wire abort_start = wr_mode & ~w_start;
	wire abort_en    = wr_ctrl & ~w_en & en_reg;
	wire cancel      = start_reg & (abort_start | abort_en);

	// Requests to the engine; the pattern is only taken on launch, so
	// the engine may watch the write bus directly.
	assign fill_bus.launch  = launch;
	assign fill_bus.cancel  = cancel;
	assign fill_bus.enable  = en_reg;
	assign fill_bus.pattern = w_pat;

	// Start bit: a real zero to one write always takes effect; completion
	// and abort clear it, otherwise the written value stands. Completion
	// beats a simultaneous rewrite of a one, so software never sees a
	// start bit that stays high after the fill has ended.
	always_comb begin
		start_next = start_reg;
		if (launch) begin
			start_next = 1'b1;
		end else if (fill_bus.done | cancel) begin
			start_next = 1'b0;
		end else if (wr_mode) begin
			start_next = w_start;
		end
	end

	// Read word assembly; reserved bits read as zero because they are
	// never stored, which saves flops that would carry no function.
	wire [15:0] rd_ctrl  = {15'h0000, en_reg};
	wire [15:0] rd_mode  = {7'h00, mode_hi_reg, pat_reg, start_reg};
	wire [15:0] rd_swrst = {14'h0000, srst_reg, 1'b0};

	// Read selection by address; an unmapped address reads as zero so
	// that a stray read cannot be mistaken for a live register.
	always_comb begin
		if (sel_ctrl) begin
			rd_word = rd_ctrl;
		end else if (sel_mode) begin
			rd_word = rd_mode;
		end else if (sel_swrst) begin
			rd_word = rd_swrst;
		end else begin
			rd_word = `BPSR_RST_WORD;
		end
	end

	// Control register: the fill enable. Only bit 0 is stored; a fill
	// that is armed waits here until software sets it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_reg <= 1'b0;
		end else if (ce && wr_ctrl) begin
			en_reg <= w_en;
		end
	end

	// Mode register: pattern and the other stored mode bits. The stored
	// bits only change on a write; software keeps them while start is
	// high, so no check is made here. The engine holds its own copy of
	// the pattern from launch, so a careless rewrite cannot alter words
	// already in flight.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pat_reg     <= `BPSR_RST_PAT;
			mode_hi_reg <= `BPSR_RST_MODE_HI;
		end else if (ce && wr_mode) begin
			pat_reg     <= w_pat;
			mode_hi_reg <= w_hi;
		end
	end

	// Start bit register; its next value is worked out above so that
	// launch, completion and abort are weighed in one place.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			start_reg <= 1'b0;
		end else if (ce) begin
			start_reg <= start_next;
		end
	end

	// Switch soft reset; reserved bits are not stored at all. The bit
	// holds only the switching blocks: this bank and a running fill go
	// on as before, so software can always clear it again.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			srst_reg <= 1'b0;
		end else if (ce && wr_swrst) begin
			srst_reg <= w_srst;
		end
	end

	// Read data register, valid only in the cycle after the strobe. The
	// word returns to zero after that cycle, so a master that samples one
	// cycle late sees zero rather than stale data.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= `BPSR_RST_WORD;
		end else if (ce) begin
			rdata_reg <= reg_rd ? rd_word : `BPSR_RST_WORD;
		end
	end

	// Busy flag held in a flop so the output comes straight from one.
	// It lags the engine by one cycle; software polling the start bit
	// never notices the difference.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
		end else if (ce) begin
			busy_reg <= fill_bus.busy;
		end
	end

	// Register outputs, each straight from its flop.
	assign reg_rdata          = rdata_reg;
	assign block_fill_enable  = en_reg;
	assign block_fill_pattern = pat_reg;
	assign mode_bits          = mode_hi_reg;
	assign fill_busy          = busy_reg;
	assign switch_reset       = srst_reg;

	// Memory write port; these come from flops inside the engine, so the
	// port stays clean of decode glitches.
	assign cm_wr_en           = fill_bus.cm_wr_en;
	assign cm_addr            = fill_bus.cm_addr;
	assign cm_wdata           = fill_bus.cm_wdata;
endmodule

// >>> testbench/bpsr_top_properties.sv
// Purpose: Port assertions for the block fill register bank.
// Assumes: ce high; synchronous active-low reset.
// Notes:   Bound to bpsr_top from the bench top file.
`timescale 1ns/1ps
`include "bpsr_map.svh"
module bpsr_top_properties #(
	parameter int CM_AW    = 11,
	parameter int CM_DW    = 16,
	parameter int MAX_BUSY = 4000
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               ce,
	input wire logic [`BPSR_AW-1:0] reg_addr,
	input wire logic [15:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [15:0]        reg_rdata,
	input wire logic               frame_pulse,
	input wire logic               block_fill_enable,
	input wire logic [2:0]         block_fill_pattern,
	input wire logic [4:0]         mode_bits,
	input wire logic               fill_busy,
	input wire logic               switch_reset,
	input wire logic               cm_wr_en,
	input wire logic [CM_AW-1:0]   cm_addr,
	input wire logic [CM_DW-1:0]   cm_wdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Cycles spent busy; waiting for enable and a frame is included.
	logic [15:0] busy_cnt_reg;
	always_ff @(posedge clk) begin
		if (!rst_n || !fill_busy)
			busy_cnt_reg <= 16'h0000;
		else
			busy_cnt_reg <= busy_cnt_reg + 16'h0001;
	end

	sequence s_mode_wr;
		reg_wr && reg_addr == `BPSR_OFS_MODE;
	endsequence
	sequence s_launch;
		s_mode_wr ##0 reg_wdata[0] && !fill_busy;
	endsequence
	sequence s_en_abort;
		reg_wr && reg_addr == `BPSR_OFS_CTRL && !reg_wdata[0]
			&& block_fill_enable && fill_busy;
	endsequence

	a_launch_arms: assert property (s_launch |-> ##[1:3] fill_busy)
		else $error("launch did not arm the fill");
	a_pattern_taken: assert property (s_launch |=>
		block_fill_pattern == $past(reg_wdata[3:1]))
		else $error("pattern not taken with start");
	a_word_pattern: assert property (cm_wr_en |->
		cm_wdata[2:0] == block_fill_pattern && fill_busy)
		else $error("memory word lacks pattern");
	a_fill_bound: assert property (busy_cnt_reg < MAX_BUSY)
		else $error("fill ran too long");
	a_start_abort: assert property ((s_mode_wr ##0 !reg_wdata[0]
		&& fill_busy) |-> ##[1:3] !fill_busy)
		else $error("start clear did not abort");
	a_enable_abort: assert property (s_en_abort |->
		##2 (!cm_wr_en && !fill_busy) [*2])
		else $error("enable clear did not abort");
	a_reset_bit: assert property ((reg_wr &&
		reg_addr == `BPSR_OFS_SWRST) |=> switch_reset == $past(reg_wdata[1]))
		else $error("switch reset bit not applied");
	a_reset_hold: assert property (!(reg_wr &&
		reg_addr == `BPSR_OFS_SWRST) |=> $stable(switch_reset))
		else $error("switch reset changed unasked");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
endmodule

// >>> testbench/bpsr_host_model.sv
// Purpose: Host processor on the register bus.
// Assumes: Slave never waits; read data stand one cycle.
// Notes:   Released lines carry the inverse of the last value.
`timescale 1ns/1ps
`include "bpsr_map.svh"
module bpsr_host_model (
	input  wire logic               clk,
	output logic [`BPSR_AW-1:0]     reg_addr,
	output logic [15:0]             reg_wdata,
	output logic                    reg_wr,
	output logic                    reg_rd,
	input  wire logic [15:0]        reg_rdata
);
	// Idle bus at time zero.
	initial begin
		reg_addr = '0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Whole words in one strobe, so start and pattern travel together.
	// Callers pass unchanged other bits; reserved bits are zero except in t_regs.
	task automatic wr(input logic [`BPSR_AW-1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// Data are taken at the edge that closes their only cycle.
	task automatic rd(input logic [`BPSR_AW-1:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	endtask
endmodule

// >>> testbench/bpsr_test.sv
// Purpose: Self-checking bench for the block fill register bank.
// Assumes: ce is held high; frames are long enough for a whole fill.
// Notes:   A word monitor checks every memory write.
`timescale 1ns/1ps
`include "bpsr_map.svh"
module bpsr_test;
	localparam int FRAME = 1100; // Above 1024 so 2048 words fit in 2.
	logic clk, rst_n, ce, frame_pulse, reg_wr, reg_rd;
	logic block_fill_enable, fill_busy, switch_reset, cm_wr_en;
	logic [`BPSR_AW-1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, cm_wdata, d;
	logic [10:0] cm_addr;
	logic [4:0] mode_bits;
	logic [2:0] block_fill_pattern, exp_pat;
	int errors = 0, checks = 0, cycles = 0, fcnt = 0, words = 0, n, t0;

	bpsr_top bpsr_top_i (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_pulse(frame_pulse),
		.block_fill_enable(block_fill_enable), .mode_bits(mode_bits),
		.block_fill_pattern(block_fill_pattern), .fill_busy(fill_busy),
		.switch_reset(switch_reset), .cm_wr_en(cm_wr_en),
		.cm_addr(cm_addr), .cm_wdata(cm_wdata));
	bpsr_host_model bpsr_host_model_i (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rchk(input logic [13:0] a, input logic [15:0] e);
		bpsr_host_model_i.rd(a, d);
		chk("register read", e, d);
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Frame strobes, cycle count and the hang limit.
	always @(posedge clk) begin
		fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
		frame_pulse <= (fcnt == FRAME - 1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			end_sim();
		end
	end

	// Every word lands in order and carries the pattern.
	always @(posedge clk) begin
		if (cm_wr_en === 1'b1) begin
			chk("cm_addr", 16'(words % 2048), 16'(cm_addr));
			chk("cm_wdata", {13'h0000, exp_pat}, cm_wdata);
			words++;
		end
	end

	task automatic t_regs;
		rchk(`BPSR_OFS_CTRL, 16'h0000);
		rchk(`BPSR_OFS_MODE, 16'h0000);
		rchk(`BPSR_OFS_SWRST, 16'h0000);
		bpsr_host_model_i.wr(`BPSR_OFS_MODE, 16'hfff0);
		rchk(`BPSR_OFS_MODE, 16'h01f0);
		chk("mode_bits", 16'h001f, 16'(mode_bits));
		bpsr_host_model_i.wr(`BPSR_OFS_MODE, 16'h0000);
		bpsr_host_model_i.wr(14'h0003, 16'hffff);
		rchk(14'h0003, 16'h0000);
		$display("test regs done");
	endtask

	task automatic t_sreset;
		bpsr_host_model_i.wr(`BPSR_OFS_SWRST, 16'h0002);
		@(negedge clk);
		chk("switch_reset", 16'h0001, 16'(switch_reset));
		rchk(`BPSR_OFS_SWRST, 16'h0002);
		bpsr_host_model_i.wr(`BPSR_OFS_SWRST, 16'h0000);
		@(negedge clk);
		chk("switch_reset", 16'h0000, 16'(switch_reset));
		$display("test sreset done");
	endtask

	task automatic t_fill;
		exp_pat = 3'h5;
		words = 0;
		bpsr_host_model_i.wr(`BPSR_OFS_CTRL, 16'h0001);
		@(negedge clk);
		chk("fill enable", 16'h0001, 16'(block_fill_enable));
		rchk(`BPSR_OFS_CTRL, 16'h0001);
		bpsr_host_model_i.wr(`BPSR_OFS_MODE, 16'h000b);
		for (n = 0; n < 3000 && words == 0; n++) @(posedge clk);
		bpsr_host_model_i.wr(`BPSR_OFS_MODE, 16'h000b);
		t0 = cycles;
		do bpsr_host_model_i.rd(`BPSR_OFS_MODE, d);
		while (d[0] === 1'b1 && cycles - t0 < 3 * FRAME);
		chk("fill time", 16'h0001, 16'(cycles - t0 <= 2 * FRAME + 8));
		chk("fill words", 16'h0800, 16'(words));
		chk("start self clear", 16'h000a, d);
		$display("test fill done");
	endtask

	// Abort by clearing start, then by clearing the enable.
	task automatic t_abort;
		exp_pat = 3'h3;
		for (int k = 0; k < 2; k++) begin
			words = 0;
			bpsr_host_model_i.wr(`BPSR_OFS_CTRL, 16'h0001);
			bpsr_host_model_i.wr(`BPSR_OFS_MODE, 16'h0007);
			for (n = 0; n < 3000 && words == 0; n++) @(posedge clk);
			if (k == 0)
				bpsr_host_model_i.wr(`BPSR_OFS_MODE, 16'h0006);
			else
				bpsr_host_model_i.wr(`BPSR_OFS_CTRL, 16'h0000);
			repeat (4) @(posedge clk);
			n = words;
			repeat (20) @(posedge clk);
			chk("words after abort", 16'(n), 16'(words));
			if (k == 1)
				chk("fill enable", 16'h0000, 16'(block_fill_enable));
			rchk(`BPSR_OFS_MODE, 16'h0006);
			@(negedge clk);
			chk("fill_busy", 16'h0000, 16'(fill_busy));
		end
		$display("test abort done");
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		exp_pat = 3'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_sreset();
		t_fill();
		t_abort();
		end_sim();
	end
endmodule

bind bpsr_top bpsr_top_properties #(.CM_AW(CM_AW), .CM_DW(CM_DW))
	bpsr_top_properties_i (.*);
